// File: cpu_regs_pkg.sv
// Shared constants and carrier types of the processor register set
package cpu_regs_pkg;

   // ==========================================================
   // Widths
   localparam int WORD_W = 16;
   localparam int LONG_W = 20;
   localparam int BUS_W = 32;
   localparam int ADDR_W = 5;
   localparam int BANK_REGS = 7;
   localparam int BANKS = 2;
   localparam int STATUS_W = 11;
   localparam int IPL_W = 3;
   localparam int VEC_W = 6;

   // ==========================================================
   // Register indices on the access port
   localparam logic [ADDR_W-1:0] IDX_DATA0 = 5'h00;
   localparam logic [ADDR_W-1:0] IDX_DATA1 = 5'h01;
   localparam logic [ADDR_W-1:0] IDX_DATA2 = 5'h02;
   localparam logic [ADDR_W-1:0] IDX_DATA3 = 5'h03;
   localparam logic [ADDR_W-1:0] IDX_ADDR0 = 5'h04;
   localparam logic [ADDR_W-1:0] IDX_ADDR1 = 5'h05;
   localparam logic [ADDR_W-1:0] IDX_FRAME = 5'h06;
   localparam logic [ADDR_W-1:0] IDX_VTB = 5'h07;
   localparam logic [ADDR_W-1:0] IDX_IP = 5'h08;
   localparam logic [ADDR_W-1:0] IDX_USP = 5'h09;
   localparam logic [ADDR_W-1:0] IDX_ISP = 5'h0A;
   localparam logic [ADDR_W-1:0] IDX_SB = 5'h0B;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] IDX_D0_HI = 5'h0D;
   localparam logic [ADDR_W-1:0] IDX_D0_LO = 5'h0E;
   localparam logic [ADDR_W-1:0] IDX_D1_HI = 5'h0F;
   localparam logic [ADDR_W-1:0] IDX_D1_LO = 5'h10;
   localparam logic [ADDR_W-1:0] IDX_PAIR_LOW = 5'h11;
   localparam logic [ADDR_W-1:0] IDX_PAIR_HIGH = 5'h12;
   localparam logic [ADDR_W-1:0] IDX_ADDR_PAIR = 5'h13;
   localparam logic [ADDR_W-1:0] IDX_ACTIVE_SP = 5'h14;

   // ==========================================================
   // Status bit positions, internal and software view
   localparam int ST_C = 0;
   localparam int ST_D = 1;
   localparam int ST_Z = 2;
   localparam int ST_S = 3;
   localparam int ST_B = 4;
   localparam int ST_O = 5;
   localparam int ST_I = 6;
   localparam int ST_U = 7;
   localparam int ST_IPL_LSB = 8;
   localparam int VIEW_IPL_LSB = 12;
   localparam logic [VEC_W-1:0] SWI_U_MAX = 6'h1F;

   // ==========================================================
   // Reset values
   localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
   localparam logic [LONG_W-1:0] RST_LONG = 20'h00000;
   localparam logic [STATUS_W-1:0] RST_STATUS = 11'h000;

   // ==========================================================
   // Carriers
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;

   typedef struct packed {
      logic upd;
      logic carry;
      logic overflow;
      op_size_t size;
      logic [BUS_W-1:0] result;
   } alu_flags_t;

   typedef struct packed {
      logic hw_accept;
      logic sw_exec;
      logic [VEC_W-1:0] sw_vector;
      logic [IPL_W-1:0] new_level;
   } int_accept_t;

   typedef struct packed {
      logic valid;
      logic [IPL_W-1:0] level;
   } irq_req_t;

   typedef struct packed {
      logic [LONG_W-1:0] ip;
      logic [LONG_W-1:0] vtb;
      logic [WORD_W-1:0] sb;
      logic [WORD_W-1:0] user_stack_pointer;
      logic [WORD_W-1:0] interrupt_stack_pointer;
   } core_view_t;

endpackage

// File: status_word_unit.sv
// Status word with arithmetic flags, control bits and interrupt gate
`timescale 1ns/100ps
`default_nettype none
module status_word_unit
   import cpu_regs_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Software write in register view
   input wire logic sw_wr,
   input wire logic [WORD_W-1:0] sw_data,
   // Execution and interrupt logic
   input wire alu_flags_t alu,
   input wire int_accept_t acc,
   input wire irq_req_t req,
   // State
   output logic [STATUS_W-1:0] status_r,
   output logic irq_ok_r
);

   logic [STATUS_W-1:0] status_nxt;
   logic res_zero;
   logic res_neg;

   // ==========================================================
   // Result tests by operand size
   always_comb
   begin
      case (alu.size)
         SZ_BYTE:
         begin
            res_zero = (alu.result[7:0] == 8'h00);
            res_neg = alu.result[7];
         end
         SZ_WORD:
         begin
            res_zero = (alu.result[15:0] == 16'h0000);
            res_neg = alu.result[15];
         end
         default:
         begin
            res_zero = (alu.result == 32'h00000000);
            res_neg = alu.result[31];
         end
      endcase
   end

   // ==========================================================
   // Update order: software, then arithmetic, then interrupt entry
   always_comb
   begin
      status_nxt = status_r;
      if (sw_wr)
      begin
         status_nxt[ST_U:ST_C] = sw_data[ST_U:ST_C];
         status_nxt[ST_IPL_LSB +: IPL_W] = sw_data[VIEW_IPL_LSB +: IPL_W];
      end
      if (alu.upd)
      begin
         status_nxt[ST_C] = alu.carry;
         status_nxt[ST_Z] = res_zero;
         status_nxt[ST_S] = res_neg;
         status_nxt[ST_O] = alu.overflow;
      end
      if (acc.hw_accept)
      begin
         status_nxt[ST_I] = 1'b0;
         status_nxt[ST_U] = 1'b0;
         status_nxt[ST_IPL_LSB +: IPL_W] = acc.new_level;
      end
      if (acc.sw_exec)
      begin
         status_nxt[ST_I] = 1'b0;
         if (acc.sw_vector <= SWI_U_MAX)
         begin
            status_nxt[ST_U] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         status_r <= RST_STATUS;
      else
         status_r <= status_nxt;
   end

   // Maskable request passes only above the current level
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         irq_ok_r <= 1'b0;
      else
         irq_ok_r <= req.valid & status_r[ST_I]
            & (req.level > status_r[ST_IPL_LSB +: IPL_W]);
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   AST_HW_ACCEPT_CLEARS: assert property (
      acc.hw_accept |=> !status_r[ST_U] && !status_r[ST_I])
      else $error("interrupt entry left U or I set");
   AST_SWI_LOW_CLEARS_U: assert property (
      acc.sw_exec && acc.sw_vector <= SWI_U_MAX |=> !status_r[ST_U])
      else $error("low software vector left U set");
   AST_ZERO_SIGN_WORD: assert property (
      alu.upd && alu.size == SZ_WORD && !acc.hw_accept |=>
      status_r[ST_Z] == ($past(alu.result[15:0]) == 16'h0000)
      && status_r[ST_S] == $past(alu.result[15]))
      else $error("zero or sign flag wrong for word result");
   AST_CARRY_OVF: assert property (
      alu.upd |=> status_r[ST_C] == $past(alu.carry)
      && status_r[ST_O] == $past(alu.overflow))
      else $error("carry or overflow not captured");
   AST_IRQ_GATE: assert property (
      irq_ok_r |-> $past(status_r[ST_I]) && $past(req.valid)
      && $past(req.level) > $past(status_r[ST_IPL_LSB +: IPL_W]))
      else $error("interrupt allowed at or below level");

endmodule
`default_nettype wire

// File: cpu_register_set.sv
// Programmer-visible register set of the processor core
// What this block does
// - Thirteen registers; data, address and frame registers exist in two banks.
// - Data registers are 16 bits; first two also reachable as byte halves.
// - Data 2:0 and 3:1 pair into 32-bit registers, higher index upper.
// - Address registers are 16 bits; they pair into 32 bits, register 1 upper.
// - Frame base and static base are 16-bit relative addressing bases.
// - Vector table base is 20 bits and holds the vector table start.
// - Instruction pointer is 20 bits, address of next instruction.
// - Two 16-bit stack pointers; stack select 0 interrupt, 1 user.
// - Stack select clears on hardware interrupt or software vector 0 to 31.
// - Status word is 11 bits: arithmetic flags, control bits, priority level.
// - Carry captures carry, borrow or shifted-out bit of the ALU.
// - Zero flag is 1 for a zero result, else 0.
// - Sign flag is 1 for a negative result, else 0.
// - Overflow flag is 1 on overflow, else 0.
// - Bank select bit routes all banked accesses to bank 0 or 1.
// - Interrupt enable gates maskable interrupts; accepting one clears it.
// - Three-bit priority field; request enabled only when strictly above it.
// - Software writes 0 to reserved status bits; reads are undefined.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_set
   import cpu_regs_pkg::*;
#(
   parameter int NUM_BANKS = BANKS,
   parameter int NUM_BANK_REGS = BANK_REGS
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register access port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [BUS_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [BUS_W-1:0] reg_rdata,
   // Execution datapath and interrupt acceptance
   input wire alu_flags_t alu_flags,
   input wire int_accept_t int_accept,
   input wire irq_req_t irq_req,
   // Core state
   output logic [STATUS_W-1:0] status_word,
   output logic irq_allowed,
   output core_view_t core_view
);

   typedef struct packed {
      logic lo;
      logic hi;
      logic [WORD_W-1:0] val;
   } entry_wr_t;

   logic [WORD_W-1:0] bank_r [0:NUM_BANKS-1][0:NUM_BANK_REGS-1];
   logic [WORD_W-1:0] cur [0:NUM_BANK_REGS-1];
   entry_wr_t ent_wr [0:NUM_BANK_REGS-1];
   logic [LONG_W-1:0] vtb_r;
   logic [LONG_W-1:0] ip_r;
   logic [WORD_W-1:0] usp_r;
   logic [WORD_W-1:0] isp_r;
   logic [WORD_W-1:0] sb_r;
   logic [BUS_W-1:0] rdata_r;
   logic [BUS_W-1:0] read_nxt;
   logic [WORD_W-1:0] status_view;
   logic status_wr;
   logic bank_sel;
   logic user_sel;

   assign bank_sel = status_word[ST_B];
   assign user_sel = status_word[ST_U];
   assign status_wr = reg_wr && (reg_addr == IDX_STATUS);

   // ==========================================================
   // Write decode for one banked entry from every alias
   function automatic entry_wr_t entry_write(
      input int k,
      input logic [ADDR_W-1:0] a,
      input logic [BUS_W-1:0] d
   );
      entry_wr_t e;
      e = '{lo: 1'b0, hi: 1'b0, val: d[WORD_W-1:0]};
      if (a == ADDR_W'(k))
      begin
         e.lo = 1'b1;
         e.hi = 1'b1;
      end
      else
      begin
         case (a)
            IDX_D0_HI, IDX_D1_HI:
            begin
               e.hi = (k == 32'(a == IDX_D1_HI));
               e.val = {d[7:0], d[7:0]};
            end
            IDX_D0_LO, IDX_D1_LO:
            begin
               e.lo = (k == 32'(a == IDX_D1_LO));
            end
            IDX_PAIR_LOW:
            begin
               e.lo = (k == 0) || (k == 2);
               e.hi = e.lo;
               e.val = (k == 2) ? d[31:16] : d[15:0];
            end
            IDX_PAIR_HIGH:
            begin
               e.lo = (k == 1) || (k == 3);
               e.hi = e.lo;
               e.val = (k == 3) ? d[31:16] : d[15:0];
            end
            IDX_ADDR_PAIR:
            begin
               e.lo = (k == 4) || (k == 5);
               e.hi = e.lo;
               e.val = (k == 5) ? d[31:16] : d[15:0];
            end
            default:
            begin
               e.lo = 1'b0;
            end
         endcase
      end
      return e;
   endfunction

   // ==========================================================
   // Banked data, address and frame registers
   generate
      for (genvar k = 0; k < NUM_BANK_REGS; k++)
      begin : g_entry
         always_comb
         begin
            ent_wr[k] = entry_write(k, reg_addr, reg_wdata);
            ent_wr[k].lo = ent_wr[k].lo & reg_wr;
            ent_wr[k].hi = ent_wr[k].hi & reg_wr;
         end

         // Current bank view used by reads
         assign cur[k] = bank_r[bank_sel][k];

         for (genvar b = 0; b < NUM_BANKS; b++)
         begin : g_bank
            always_ff @(posedge clock)
            begin
               if (!reset_n)
                  bank_r[b][k] <= RST_WORD;
               else if (32'(bank_sel) == b)
               begin
                  if (ent_wr[k].lo)
                     bank_r[b][k][7:0] <= ent_wr[k].val[7:0];
                  if (ent_wr[k].hi)
                     bank_r[b][k][15:8] <= ent_wr[k].val[15:8];
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Single-copy registers
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         vtb_r <= RST_LONG;
      else if (reg_wr && reg_addr == IDX_VTB)
         vtb_r <= reg_wdata[LONG_W-1:0];
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         ip_r <= RST_LONG;
      else if (reg_wr && reg_addr == IDX_IP)
         ip_r <= reg_wdata[LONG_W-1:0];
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         sb_r <= RST_WORD;
      else if (reg_wr && reg_addr == IDX_SB)
         sb_r <= reg_wdata[WORD_W-1:0];
   end

   // Stack pointers: direct names or the one that stack select picks
   always_ff @(posedge clock)
   begin
      if (!reset_n)
         usp_r <= RST_WORD;
      else if (reg_wr && (reg_addr == IDX_USP
               || (reg_addr == IDX_ACTIVE_SP && user_sel)))
         usp_r <= reg_wdata[WORD_W-1:0];
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         isp_r <= RST_WORD;
      else if (reg_wr && (reg_addr == IDX_ISP
               || (reg_addr == IDX_ACTIVE_SP && !user_sel)))
         isp_r <= reg_wdata[WORD_W-1:0];
   end

   // ==========================================================
   // Status word
   status_word_unit u_status
   (
      .clock(clock),
      .reset_n(reset_n),
      .sw_wr(status_wr),
      .sw_data(reg_wdata[WORD_W-1:0]),
      .alu(alu_flags),
      .acc(int_accept),
      .req(irq_req),
      .status_r(status_word),
      .irq_ok_r(irq_allowed)
   );

   // Reserved view bits read as zero
   always_comb
   begin
      status_view = '0;
      status_view[ST_U:ST_C] = status_word[ST_U:ST_C];
      status_view[VIEW_IPL_LSB +: IPL_W] = status_word[ST_IPL_LSB +: IPL_W];
   end

   // ==========================================================
   // Read path: data valid only in the cycle after the strobe
   always_comb
   begin
      read_nxt = '0;
      case (reg_addr)
         IDX_DATA0, IDX_DATA1, IDX_DATA2, IDX_DATA3,
         IDX_ADDR0, IDX_ADDR1, IDX_FRAME:
            read_nxt[WORD_W-1:0] = cur[reg_addr[2:0]];
         IDX_VTB:
            read_nxt[LONG_W-1:0] = vtb_r;
         IDX_IP:
            read_nxt[LONG_W-1:0] = ip_r;
         IDX_USP:
            read_nxt[WORD_W-1:0] = usp_r;
         IDX_ISP:
            read_nxt[WORD_W-1:0] = isp_r;
         IDX_SB:
            read_nxt[WORD_W-1:0] = sb_r;
         IDX_STATUS:
            read_nxt[WORD_W-1:0] = status_view;
         IDX_D0_HI:
            read_nxt[7:0] = cur[0][15:8];
         IDX_D0_LO:
            read_nxt[7:0] = cur[0][7:0];
         IDX_D1_HI:
            read_nxt[7:0] = cur[1][15:8];
         IDX_D1_LO:
            read_nxt[7:0] = cur[1][7:0];
         IDX_PAIR_LOW:
            read_nxt = {cur[2], cur[0]};
         IDX_PAIR_HIGH:
            read_nxt = {cur[3], cur[1]};
         IDX_ADDR_PAIR:
            read_nxt = {cur[5], cur[4]};
         IDX_ACTIVE_SP:
            read_nxt[WORD_W-1:0] = user_sel ? usp_r : isp_r;
         default:
            read_nxt = '0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
         rdata_r <= '0;
      else if (reg_rd)
         rdata_r <= read_nxt;
      else
         rdata_r <= '0;
   end

   assign reg_rdata = rdata_r;

   // Core state handed to the datapath
   always_comb
   begin
      core_view.ip = ip_r;
      core_view.vtb = vtb_r;
      core_view.sb = sb_r;
      core_view.user_stack_pointer = usp_r;
      core_view.interrupt_stack_pointer = isp_r;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_write(logic [ADDR_W-1:0] a);
      reg_wr && reg_addr == a && !status_wr;
   endsequence

   sequence s_read_back(logic [ADDR_W-1:0] a);
      reg_rd && reg_addr == a && !reg_wr;
   endsequence

   AST_READ_ONE_CYCLE: assert property (
      !reg_rd |=> reg_rdata == '0)
      else $error("read data present without a read strobe");
   AST_BANK_ROUTE: assert property (
      s_write(IDX_DATA0) |=> bank_r[bank_sel][0] == $past(reg_wdata[15:0])
      && bank_r[!bank_sel][0] == $past(bank_r[!bank_sel][0]))
      else $error("data write reached the wrong bank");
   AST_PAIR_ORDER: assert property (
      s_write(IDX_PAIR_LOW) |=> cur[2] == $past(reg_wdata[31:16])
      && cur[0] == $past(reg_wdata[15:0]))
      else $error("data pair halves misplaced");
   AST_ADDR_PAIR: assert property (
      s_write(IDX_ADDR_PAIR) ##1 s_read_back(IDX_ADDR_PAIR)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("address pair read back differs");
   AST_BYTE_HALF: assert property (
      s_write(IDX_D0_HI) |=> cur[0][15:8] == $past(reg_wdata[7:0])
      && cur[0][7:0] == $past(cur[0][7:0]))
      else $error("upper byte write disturbed lower byte");
   AST_BYTE_LOW: assert property (
      s_write(IDX_D1_LO) |=> cur[1][7:0] == $past(reg_wdata[7:0])
      && cur[1][15:8] == $past(cur[1][15:8]))
      else $error("lower byte write disturbed upper byte");
   AST_SINGLE_SB: assert property (
      s_write(IDX_SB) |=> core_view.sb == $past(reg_wdata[15:0]))
      else $error("static base not loaded");
   AST_VTB_LOAD: assert property (
      s_write(IDX_VTB) |=> core_view.vtb == $past(reg_wdata[19:0]))
      else $error("vector table base not loaded");
   AST_STATUS_VIEW: assert property (
      s_read_back(IDX_STATUS) |=> reg_rdata[31:15] == '0 && reg_rdata[11:8] == '0
      && reg_rdata[7:0] == $past(status_word[7:0])
      && reg_rdata[14:12] == $past(status_word[10:8]))
      else $error("status view bits misplaced");
   AST_ACTIVE_SP: assert property (
      reg_rd && reg_addr == IDX_ACTIVE_SP |=>
      reg_rdata[15:0] == ($past(user_sel) ? $past(usp_r) : $past(isp_r)))
      else $error("active stack pointer does not follow stack select");

endmodule
`default_nettype wire

// File: core_side_model.sv
// Behavioural model of the core datapath and interrupt acceptance feeding the register set
`timescale 1ns/100ps
`default_nettype none
module core_side_model
   import cpu_regs_pkg::*;
(
   // Clock
   input wire logic clock,
   // Toward the register set
   output var alu_flags_t alu_flags,
   output var int_accept_t int_accept,
   output var irq_req_t irq_req
);
   // ==========================================================
   // Idle state
   initial
   begin
      alu_flags = '0;
      int_accept = '0;
      irq_req = '0;
   end

   // ==========================================================
   // Operations, each issued right after a rising edge
   // Released fields other than the size show inverted values so stale data is never reused
   task automatic alu_op(input op_size_t sz, input logic [BUS_W-1:0] res, input logic c,
                         input logic o);
      alu_flags <= '{1'h1, c, o, sz, res};
      @(posedge clock);
      alu_flags <= '{1'h0, ~c, ~o, sz, ~res};
      @(posedge clock);
   endtask

   // Hardware entry when hw is high, software interrupt instruction otherwise
   task automatic accept(input logic hw, input logic [VEC_W-1:0] vec,
                         input logic [IPL_W-1:0] lvl);
      int_accept <= '{hw, ~hw, vec, lvl};
      @(posedge clock);
      int_accept <= '{1'h0, 1'h0, ~vec, ~lvl};
      @(posedge clock);
   endtask

   task automatic request(input logic v, input logic [IPL_W-1:0] lvl);
      irq_req <= '{v, lvl};
      @(posedge clock);
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

// File: tb_cpu_register_set.sv
// Self-checking testbench of the processor register set
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_register_set
   import cpu_regs_pkg::*;
;
   logic clock;
   logic reset_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [BUS_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [BUS_W-1:0] reg_rdata;
   alu_flags_t alu_flags;
   int_accept_t int_accept;
   irq_req_t irq_req;
   logic [STATUS_W-1:0] status_word;
   logic irq_allowed;
   core_view_t core_view;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;

   cpu_register_set i_cpu_register_set (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .alu_flags(alu_flags), .int_accept(int_accept), .irq_req(irq_req),
      .status_word(status_word), .irq_allowed(irq_allowed), .core_view(core_view));

   core_side_model i_core_side_model (.clock(clock), .alu_flags(alu_flags),
      .int_accept(int_accept), .irq_req(irq_req));

   // ==========================================================
   // Clock and run limit
   initial
   begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         mismatches++;
         results();
      end
   end

   // ==========================================================
   // Helpers
   task automatic results();
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clock);
      reg_wr <= 1'h0;
      reg_wdata <= ~d;
      @(posedge clock);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] e);
      logic [BUS_W-1:0] v;
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clock);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      #1 v = reg_rdata;
      chk(v, e);
      @(posedge clock);
   endtask

   // Write followed by a read of the same index with no gap
   task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clock);
      reg_wr <= 1'h0;
      rdchk(a, d);
   endtask

   // Software view of the status word
   function automatic logic [BUS_W-1:0] sv(input logic [2:0] p, input logic u, input logic i,
                                           input logic b);
      return {17'h0, p, 4'h0, u, i, 1'h0, b, 4'h0};
   endfunction

   // Internal status word
   function automatic logic [BUS_W-1:0] stw(input logic [2:0] p, input logic u, input logic i,
      input logic o, input logic b, input logic s, input logic z, input logic c);
      return {21'h0, p, u, i, o, b, s, z, 1'h0, c};
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk(BUS_W'(status_word), 32'h0);
      chk(BUS_W'(irq_allowed), 32'h0);
      for (int k = 0; k < 32; k++)
         rdchk(ADDR_W'(k), 32'h0);
   endtask

   task automatic t_single();
      for (int k = 0; k < 12; k++)
         wr(ADDR_W'(k), 32'hFEDC_BA90 + k);
      wr(5'h17, 32'hFFFF_FFFF);
      for (int k = 0; k < 12; k++)
         rdchk(ADDR_W'(k), (32'hFEDC_BA90 + k) & ((k == 7 || k == 8) ? 32'hF_FFFF : 32'hFFFF));
      rdchk(5'h17, 32'h0);
      chk(BUS_W'(core_view.vtb), 32'hC_BA97);
      chk(BUS_W'(core_view.ip), 32'hC_BA98);
      chk(BUS_W'(core_view.user_stack_pointer), 32'hBA99);
      chk(BUS_W'(core_view.interrupt_stack_pointer), 32'hBA9A);
      chk(BUS_W'(core_view.sb), 32'hBA9B);
   endtask

   task automatic t_bytes();
      logic [ADDR_W-1:0] full [2] = '{IDX_DATA0, IDX_DATA1};
      logic [ADDR_W-1:0] hi [2] = '{IDX_D0_HI, IDX_D1_HI};
      logic [ADDR_W-1:0] lo [2] = '{IDX_D0_LO, IDX_D1_LO};
      for (int j = 0; j < 2; j++)
      begin
         wr(full[j], 32'h1234);
         wr(hi[j], 32'hFFFF_FFAB);
         rdchk(full[j], 32'hAB34);
         wr(lo[j], 32'hFFFF_FFCD);
         rdchk(full[j], 32'hABCD);
         rdchk(hi[j], 32'hAB);
         rdchk(lo[j], 32'hCD);
      end
   endtask

   task automatic t_pairs();
      logic [ADDR_W-1:0] pr [3] = '{IDX_PAIR_LOW, IDX_PAIR_HIGH, IDX_ADDR_PAIR};
      logic [ADDR_W-1:0] hi [3] = '{IDX_DATA2, IDX_DATA3, IDX_ADDR1};
      logic [ADDR_W-1:0] lo [3] = '{IDX_DATA0, IDX_DATA1, IDX_ADDR0};
      for (int j = 0; j < 3; j++)
      begin
         wr(pr[j], 32'hAAAA_5555 + j);
         rdchk(hi[j], 32'hAAAA);
         rdchk(lo[j], 32'h5555 + j);
         wr(hi[j], 32'h0F0F);
         rdchk(pr[j], 32'h0F0F_5555 + j);
      end
      wrrd(IDX_ADDR_PAIR, 32'h1234_5678);
   endtask

   task automatic t_banks();
      for (int k = 0; k < 7; k++)
         wr(ADDR_W'(k), 32'hA000 + k);
      wr(IDX_STATUS, sv(3'h0, 1'h0, 1'h0, 1'h1));
      chk(BUS_W'(status_word), stw(3'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0));
      for (int k = 0; k < 7; k++)
         wr(ADDR_W'(k), 32'hB000 + k);
      for (int k = 0; k < 7; k++)
         rdchk(ADDR_W'(k), 32'hB000 + k);
      rdchk(IDX_SB, 32'hBA9B);
      wr(IDX_STATUS, sv(3'h0, 1'h0, 1'h0, 1'h0));
      for (int k = 0; k < 7; k++)
         rdchk(ADDR_W'(k), 32'hA000 + k);
   endtask

   task automatic t_stack();
      wr(IDX_USP, 32'h1111);
      wr(IDX_ISP, 32'h2222);
      rdchk(IDX_ACTIVE_SP, 32'h2222);
      wr(IDX_STATUS, sv(3'h0, 1'h1, 1'h0, 1'h0));
      rdchk(IDX_ACTIVE_SP, 32'h1111);
      wr(IDX_ACTIVE_SP, 32'h3333);
      rdchk(IDX_USP, 32'h3333);
      wr(IDX_STATUS, sv(3'h0, 1'h0, 1'h0, 1'h0));
      wr(IDX_ACTIVE_SP, 32'h4444);
      rdchk(IDX_ISP, 32'h4444);
   endtask

   task automatic t_flags();
      op_size_t sz [6] = '{SZ_WORD, SZ_WORD, SZ_BYTE, SZ_BYTE, SZ_LONG, SZ_LONG};
      logic [BUS_W-1:0] res [6] = '{32'h0, 32'h1_8000, 32'h100, 32'h80, 32'h8000_0000, 32'h1_0000};
      logic [3:0] cozs [6] = '{4'h2, 4'h9, 4'h6, 4'hD, 4'h1, 4'h8};
      for (int j = 0; j < 6; j++)
      begin
         i_core_side_model.alu_op(sz[j], res[j], cozs[j][3], cozs[j][2]);
         chk(BUS_W'(status_word), stw(3'h0, 1'h0, 1'h0, cozs[j][2], 1'h0, cozs[j][0],
            cozs[j][1], cozs[j][3]));
      end
   endtask

   task automatic t_irq();
      logic [VEC_W-1:0] vec [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
      wr(IDX_STATUS, sv(3'h3, 1'h0, 1'h1, 1'h0));
      for (int lv = 0; lv < 8; lv++)
      begin
         i_core_side_model.request(1'h1, IPL_W'(lv));
         chk(BUS_W'(irq_allowed), BUS_W'(lv > 3));
      end
      i_core_side_model.request(1'h0, 3'h7);
      chk(BUS_W'(irq_allowed), 32'h0);
      wr(IDX_STATUS, sv(3'h3, 1'h0, 1'h0, 1'h0));
      i_core_side_model.request(1'h1, 3'h7);
      chk(BUS_W'(irq_allowed), 32'h0);
      wr(IDX_STATUS, sv(3'h2, 1'h1, 1'h1, 1'h0));
      i_core_side_model.accept(1'h1, 6'h05, 3'h5);
      chk(BUS_W'(status_word), stw(3'h5, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0));
      for (int j = 0; j < 4; j++)
      begin
         wr(IDX_STATUS, sv(3'h2, 1'h1, 1'h1, 1'h0));
         i_core_side_model.accept(1'h0, vec[j], 3'h2);
         chk(BUS_W'(status_word), stw(3'h2, vec[j] > 6'h1F, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
            1'h0));
      end
   endtask

   task automatic t_reserved();
      wr(IDX_STATUS, 32'h0000_70FD);
      chk(BUS_W'(status_word), 32'h7FD);
      rdchk(IDX_STATUS, 32'h70FD);
      #1 chk(reg_rdata, 32'h0);
      @(posedge clock);
      wr(IDX_STATUS, 32'h0);
   endtask

   // Reset in mid-run must clear everything that earlier scenarios loaded
   task automatic t_mid_reset();
      reset_n <= 1'h0;
      repeat (2) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      t_reset();
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      reset_n = 1'h0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      repeat (10) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      t_reset();
      t_single();
      t_bytes();
      t_pairs();
      t_banks();
      t_stack();
      t_flags();
      t_irq();
      t_reserved();
      t_mid_reset();
      results();
   end
endmodule
`default_nettype wire
